//--- bgdc_top.sv
// Brushless gate drive controller: commutation, chopping, current limit, faults, APB
//
// Functional notes
// RL1 - Fast decay, PWM low, no rectification: every gate output off.
// RL2 - PWM high: commutation-selected drivers on, regardless of decay and rectification.
// RL3 - Slow decay, PWM low, no rectification: only selected low side stays on.
// RL4 - Fast decay, PWM low, rectification on: opposite switches of the selection on.
// RL5 - Slow decay, PWM low, rectification on: both low sides of the pair on.
// RL6 - Motor reset forces all gates off and clears fault logic, overriding everything; the code lets a new overheat or short set win over its clear.
// RL7 - A programmable dead time separates every turn-off from the next turn-on.
// RL8 - High side held off while bootstrap charge current is high, no fault.
// RL9 - Hall code all zeros or all ones raises fault and coasts.
// RL10 - Gate supply below threshold holds every gate output low.
// RL11 - Overtemperature faults and coasts; clears once temperature falls below lower threshold.
// RL12 - High side on with drain-source voltage staying high flags short to ground.
// RL13 - Every commutation step clears a latched short-to-ground fault.
// RL14 - Without commutation the short fault holds until motor reset.
// RL15 - Current trip resets source latch, high side off for fixed off time.
// RL16 - After off time high side returns; comparator ignored during blanking.
// RL17 - Braking turns every low side on and every high side off.
// RL18 - Motor reset beats brake and coasts the motor.
// RL19 - Brake input is active low.
// RL20 - Six-state Hall table selects drivers; direction reverses the sequence.
// RL21 - One speed pulse per Hall input transition.
// RL22 - Short fault turns off high sides only; other faults coast everything.
// RL23 - Off, blanking and dead times are programmable cycle counts.
// RL24 - Fault output high while any fault condition is active.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module bgdc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [bgdc_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] hall_inputs,
  input wire logic pwm_in,
  input wire logic current_trip,
  input wire logic gate_supply_ok,
  input wire logic temp_over_165,
  input wire logic temp_under_155,
  input wire logic [2:0] hs_vds_high,
  input wire logic [2:0] boot_charge_high,
  output logic [2:0] high_side_gate,
  output logic [2:0] low_side_gate,
  output logic fault_out,
  output logic speed_pulse_out
);
  import bgdc_pkg::*;

  // Software-visible state
  logic [CTRL_W-1:0] ctrl_r;
  logic [DEAD_W-1:0] dead_r;
  logic [OFF_W-1:0] off_r;
  logic [BLANK_W-1:0] blank_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  // Control fields
  logic slow_decay;
  logic sync_rect_enable;
  logic dir;
  logic brake_n;
  logic motor_reset;
  // Commutation and chopping
  logic [2:0] sel_hs;
  logic [2:0] sel_ls;
  logic [2:0] hs_req;
  logic [2:0] ls_req;
  logic chop;
  logic [2:0] hall_prev_r;
  logic hall_chg;
  logic commutation;
  logic speed_pulse_r;
  logic hall_primed_r;

  // Current limit
  bgdc_cl_t cl_state_r;
  logic [OFF_W-1:0] cl_cnt_r;
  logic pwm_prev_r;

  // Faults
  logic hall_bad;
  logic uv_fault;
  logic ot_r;
  logic stg_r;
  logic [STG_W-1:0] stg_cnt_r;
  logic stg_seen;
  logic stg_set;
  logic coast;
  logic fault_r;

  // APB decode
  logic setup_ph;
  logic wr_en;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [31:0] status_word;
  bgdc_gate_if #(.DEAD_W(DEAD_W)) gif ();
  assign slow_decay = ctrl_r[CTRL_SLOW_DECAY];
  assign sync_rect_enable = ctrl_r[CTRL_SYNC_RECT];
  assign dir = ctrl_r[CTRL_DIR];
  assign brake_n = ctrl_r[CTRL_BRAKE_N];
  assign motor_reset = ctrl_r[CTRL_MOTOR_RESET];

  // APB slave: zero wait states, answer prepared in the setup cycle
  assign setup_ph = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready_r;

  // Status word shows live fault sources and gate state
  assign status_word = {16'h0000, cl_state_r, low_side_gate, high_side_gate,
                        hall_inputs, fault_r, stg_r, ot_r, uv_fault, hall_bad};

  // Read multiplexer; unmapped addresses answer zero with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      ADDR_CTRL: rd_mux = {27'h000_0000, ctrl_r};
      ADDR_DEAD: rd_mux = {24'h00_0000, dead_r};
      ADDR_OFFT: rd_mux = {16'h0000, off_r};
      ADDR_BLANK: rd_mux = {24'h00_0000, blank_r};
      ADDR_STATUS: rd_mux = status_word;
      default: rd_hit = 1'b0;
    endcase
  end

  // Answer registers; pready is high exactly in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
      if (setup_ph) begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_r <= ~rd_hit | (pwrite & paddr == ADDR_STATUS);
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // Writable registers; the status word is read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      dead_r <= DEAD_RST;
      off_r <= OFF_RST;
      blank_r <= BLANK_RST;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_CTRL: ctrl_r <= pwdata[CTRL_W-1:0];
        ADDR_DEAD: dead_r <= pwdata[DEAD_W-1:0]; // RL23
        ADDR_OFFT: off_r <= pwdata[OFF_W-1:0]; // RL23
        ADDR_BLANK: blank_r <= pwdata[BLANK_W-1:0]; // RL23
        default: ;
      endcase
    end
  end

  // Commutation table
  // Forward table; reverse simply swaps the high and low selections
  always_comb begin
    logic [2:0] fwd_hs;
    logic [2:0] fwd_ls;
    fwd_hs = 3'h0;
    fwd_ls = 3'h0;
    unique case (hall_inputs)
      3'b101: begin
        fwd_hs = 3'b001;
        fwd_ls = 3'b100;
      end
      3'b100: begin
        fwd_hs = 3'b010;
        fwd_ls = 3'b100;
      end
      3'b110: begin
        fwd_hs = 3'b010;
        fwd_ls = 3'b001;
      end
      3'b010: begin
        fwd_hs = 3'b100;
        fwd_ls = 3'b001;
      end
      3'b011: begin
        fwd_hs = 3'b100;
        fwd_ls = 3'b010;
      end
      3'b001: begin
        fwd_hs = 3'b001;
        fwd_ls = 3'b010;
      end
      default: ; // Illegal codes select nothing
    endcase
    sel_hs = dir ? fwd_hs : fwd_ls; // RL20
    sel_ls = dir ? fwd_ls : fwd_hs; // RL20
  end

  // Hall edges give speed pulse and commutation; first cycle after reset only primes
  assign hall_chg = hall_primed_r & (hall_inputs != hall_prev_r);
  assign commutation = hall_chg & ~hall_bad;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hall_prev_r <= 3'h0;
      hall_primed_r <= 1'b0;
      speed_pulse_r <= 1'b0;
    end else begin
      hall_prev_r <= hall_inputs;
      hall_primed_r <= 1'b1;
      speed_pulse_r <= hall_chg; // RL21
    end
  end

  // Fixed off-time current limit; the blank after it keeps diode recovery from retriggering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_state_r <= CL_ON;
      cl_cnt_r <= '0;
      pwm_prev_r <= 1'b0;
    end else begin
      pwm_prev_r <= pwm_in;
      if (motor_reset) begin
        cl_state_r <= CL_ON;
        cl_cnt_r <= '0;
      end else begin
        unique case (cl_state_r)
          CL_ON: begin
            if (pwm_in & ~pwm_prev_r) begin
              cl_state_r <= CL_BLANK;
              cl_cnt_r <= {{(OFF_W-BLANK_W){1'b0}}, blank_r};
            end else if (pwm_in & current_trip) begin
              cl_state_r <= CL_OFF; // RL15
              cl_cnt_r <= off_r;
            end
          end
          CL_OFF: begin
            if (cl_cnt_r <= 16'h0001) begin
              cl_state_r <= CL_BLANK; // RL16
              cl_cnt_r <= {{(OFF_W-BLANK_W){1'b0}}, blank_r};
            end else begin
              cl_cnt_r <= cl_cnt_r - 1'b1;
            end
          end
          CL_BLANK: begin
            if (cl_cnt_r <= 16'h0001) begin
              cl_state_r <= CL_ON; // RL16
              cl_cnt_r <= '0;
            end else begin
              cl_cnt_r <= cl_cnt_r - 1'b1;
            end
          end
          default: begin
            cl_state_r <= CL_ON;
            cl_cnt_r <= '0;
          end
        endcase
      end
    end
  end

  // Faults
  assign hall_bad = hall_inputs == HALL_ALL_LOW || hall_inputs == HALL_ALL_HIGH; // RL9
  assign uv_fault = ~gate_supply_ok; // RL10
  assign coast = motor_reset | hall_bad | uv_fault | ot_r; // RL22

  // Thermal flag with hysteresis; a new overheat wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_r <= 1'b0;
    end else if (temp_over_165) begin
      ot_r <= 1'b1; // RL11
    end else if (temp_under_155 | motor_reset) begin
      ot_r <= 1'b0; // RL11
    end
  end

  // Short to ground: an energised high side whose drain-source level stays
  // high for the qualify time; the filter ignores the normal switching edge
  assign stg_seen = |(high_side_gate & hs_vds_high);
  assign stg_set = stg_seen & (stg_cnt_r >= STG_QUAL - 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_cnt_r <= '0;
    end else if (!stg_seen) begin
      stg_cnt_r <= '0;
    end else if (stg_cnt_r != STG_QUAL) begin
      stg_cnt_r <= stg_cnt_r + 1'b1; // RL12
    end
  end

  // Latched until a commutation or a motor reset; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stg_r <= 1'b0;
    end else if (stg_set) begin
      stg_r <= 1'b1; // RL12
    end else if (commutation | motor_reset) begin
      stg_r <= 1'b0; // RL13 RL14 RL6
    end
  end

  // Fault pin reflects every live fault source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= hall_bad | uv_fault | ot_r | stg_r; // RL24
    end
  end

  // Gate request selection
  // Off window of the current limit recirculates like a PWM-low phase
  assign chop = ~pwm_in | (cl_state_r == CL_OFF); // RL15

  always_comb begin
    hs_req = 3'h0;
    ls_req = 3'h0;
    if (coast) begin
      hs_req = 3'h0; // RL6 RL18 RL9 RL10 RL11
      ls_req = 3'h0;
    end else if (!brake_n) begin
      ls_req = 3'h7; // RL17 RL19
    end else if (!chop) begin
      hs_req = sel_hs; // RL2
      ls_req = sel_ls;
    end else begin
      unique case ({slow_decay, sync_rect_enable})
        2'b00: ls_req = 3'h0; // RL1
        2'b10: ls_req = sel_ls; // RL3
        2'b01: begin
          hs_req = sel_ls; // RL4
          ls_req = sel_hs;
        end
        2'b11: ls_req = sel_ls | sel_hs; // RL5
      endcase
    end
    // High sides alone drop on a short or while the bootstrap charges
    hs_req = hs_req & ~{3{stg_r}} & ~boot_charge_high; // RL22 RL8
  end

  assign gif.hs_req = hs_req;
  assign gif.ls_req = ls_req;
  assign gif.dead_cyc = dead_r;

  // Dead-time stage owns the gate flip-flops
  bgdc_dead_time #(.DEAD_W(DEAD_W)) u_dead (
    .pclk(pclk),
    .presetn(presetn),
    .gif(gif)
  );

  // Output pins
  assign high_side_gate = gif.hs_gate;
  assign low_side_gate = gif.ls_gate;
  assign fault_out = fault_r;
  assign speed_pulse_out = speed_pulse_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule

//--- bgdc_pkg.sv
// Shared constants, register map and types for the brushless gate drive controller
package bgdc_pkg;
  // Clock rate and time bases
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  // Default dead time, least time, rounded up to whole cycles
  localparam int unsigned DEAD_NS = 100;
  localparam int unsigned DEAD_CYC = (DEAD_NS * CLK_PER_US + 999) / 1000;
  // Default fixed off time
  localparam int unsigned OFF_US = 10;
  localparam int unsigned OFF_CYC = OFF_US * CLK_PER_US;
  // Default comparator blanking time
  localparam int unsigned BLANK_NS = 1000;
  localparam int unsigned BLANK_CYC = (BLANK_NS * CLK_PER_US + 999) / 1000;
  // Time a high-side drain-source level must persist before a short is flagged
  localparam int unsigned STG_QUAL_NS = 500;
  localparam int unsigned STG_QUAL_CYC = (STG_QUAL_NS * CLK_PER_US + 999) / 1000;

  // Widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DEAD_W = 8;
  localparam int unsigned OFF_W = 16;
  localparam int unsigned BLANK_W = 8;
  localparam int unsigned STG_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_DEAD = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_OFFT = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_BLANK = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;

  // Control register fields
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned CTRL_SLOW_DECAY = 0;
  localparam int unsigned CTRL_SYNC_RECT = 1;
  localparam int unsigned CTRL_DIR = 2;
  localparam int unsigned CTRL_BRAKE_N = 3;
  localparam int unsigned CTRL_MOTOR_RESET = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h0F;

  // Timing register reset values and the short-to-ground qualify count
  localparam logic [DEAD_W-1:0] DEAD_RST = DEAD_W'(DEAD_CYC);
  localparam logic [OFF_W-1:0] OFF_RST = OFF_W'(OFF_CYC);
  localparam logic [BLANK_W-1:0] BLANK_RST = BLANK_W'(BLANK_CYC);
  localparam logic [STG_W-1:0] STG_QUAL = STG_W'(STG_QUAL_CYC);

  // Hall codes that never occur with 120 degree sensors
  localparam logic [2:0] HALL_ALL_LOW = 3'h0;
  localparam logic [2:0] HALL_ALL_HIGH = 3'h7;

  // Current limit phases
  typedef enum logic [1:0] {
    CL_ON = 2'b00,
    CL_OFF = 2'b01,
    CL_BLANK = 2'b10
  } bgdc_cl_t;
endpackage

//--- bgdc_gate_if.sv
// Carrier between gate selection and dead-time insertion
`timescale 1ns/1ps
interface bgdc_gate_if #(
  parameter int unsigned DEAD_W = 8
);
  logic [2:0] hs_req;
  logic [2:0] ls_req;
  logic [DEAD_W-1:0] dead_cyc;
  logic [2:0] hs_gate;
  logic [2:0] ls_gate;
  modport ctrl (output hs_req, output ls_req, output dead_cyc, input hs_gate, input ls_gate);
  modport dt (input hs_req, input ls_req, input dead_cyc, output hs_gate, output ls_gate);
endinterface

//--- bgdc_dead_time.sv
// Per-phase dead-time insertion for the six gate outputs
`timescale 1ns/1ps
module bgdc_dead_time #(
  parameter int unsigned DEAD_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  bgdc_gate_if.dt gif
);
  import bgdc_pkg::*;

  for (genvar ph = 0; ph < 3; ph++) begin : g_phase
    logic [DEAD_W-1:0] cnt_r;
    logic hs_r;
    logic ls_r;
    logic turn_off;

    // Any driver of this phase dropping restarts the gap
    assign turn_off = (hs_r & ~gif.hs_req[ph]) | (ls_r & ~gif.ls_req[ph]);

    // Gap counter, reloaded at every turn-off
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt_r <= '0;
      end else if (turn_off) begin
        cnt_r <= gif.dead_cyc; // RL7
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end

    // Turn-off is immediate; turn-on waits for the gap and a quiet partner
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hs_r <= 1'b0;
        ls_r <= 1'b0;
      end else begin
        hs_r <= gif.hs_req[ph] & (hs_r | (cnt_r == '0 & ~ls_r & ~gif.ls_req[ph])); // RL7
        ls_r <= gif.ls_req[ph] & (ls_r | (cnt_r == '0 & ~hs_r & ~gif.hs_req[ph])); // RL7
      end
    end

    assign gif.hs_gate[ph] = hs_r;
    assign gif.ls_gate[ph] = ls_r;
  end
endmodule

//--- bgdc_top_props.sv
// Port-level assertions for the brushless gate drive controller
`timescale 1ns/1ps
module bgdc_top_props (
  input logic pclk,
  input logic presetn,
  input logic [bgdc_pkg::ADDR_W-1:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  input logic [2:0] hall_inputs,
  input logic gate_supply_ok,
  input logic [2:0] boot_charge_high,
  input logic temp_over_165,
  input logic [2:0] high_side_gate,
  input logic [2:0] low_side_gate,
  input logic fault_out,
  input logic speed_pulse_out
);
  import bgdc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Both switches of one phase on together would short the supply
  AST_NO_SHOOT: assert property ((high_side_gate & low_side_gate) == 3'h0)
    else $error("high and low gate of one phase on together");
  // Gap after a high-side turn-off is the reset dead count plus one
  AST_DEAD_A: assert property ($fell(high_side_gate[0]) |-> (!low_side_gate[0])[*5])
    else $error("phase A low side on inside dead gap");
  AST_HALL_FAULT: assert property ((hall_inputs == HALL_ALL_LOW ||
    hall_inputs == HALL_ALL_HIGH) |-> ##[1:2] fault_out) else $error("bad hall without fault");
  AST_HALL_COAST: assert property ((hall_inputs == HALL_ALL_LOW)[*4]
    |-> (high_side_gate | low_side_gate) == 3'h0) else $error("bad hall not coasting");
  AST_UV_COAST: assert property ((!gate_supply_ok)[*4]
    |-> (high_side_gate | low_side_gate) == 3'h0) else $error("gates on in undervoltage");
  AST_BOOT_HOLD: assert property ((boot_charge_high & high_side_gate) == 3'h0)
    else $error("high side on while bootstrap still charging");
  AST_HOT_FAULT: assert property (temp_over_165 |-> ##[1:2] fault_out)
    else $error("overtemperature without fault");
  AST_SPEED: assert property ($changed(hall_inputs) |=> speed_pulse_out)
    else $error("hall change without speed pulse");
  // APB answer comes in the access cycle, with error for unmapped places
  AST_PREADY: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in access cycle");
  AST_SLVERR: assert property (psel && !penable && (paddr > ADDR_STATUS ||
    (pwrite && paddr == ADDR_STATUS)) |=> pready && pslverr) else $error("missing slave error");
  CVR_ERR: cover property (pslverr);
  CVR_SPEED: cover property (speed_pulse_out);
  CVR_FAULT_LOW: cover property (fault_out && low_side_gate != 3'h0);
endmodule
bind bgdc_top bgdc_top_props bgdc_top_props_i (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .hall_inputs(hall_inputs), .gate_supply_ok(gate_supply_ok),
  .temp_over_165(temp_over_165), .high_side_gate(high_side_gate),
  .boot_charge_high(boot_charge_high),
  .low_side_gate(low_side_gate), .fault_out(fault_out), .speed_pulse_out(speed_pulse_out));

//--- bgdc_bridge_model.sv
// Behavioural MOSFET bridge and motor leads driven by the gate outputs
`timescale 1ns/1ps
module bgdc_bridge_model (
  input wire logic pclk,
  input wire logic [2:0] high_side_gate,
  input wire logic [2:0] low_side_gate,
  input wire logic [2:0] lead_short,
  input wire logic slow_boot,
  output logic [2:0] hs_vds_high,
  output logic [2:0] boot_charge_high
);
  logic [3:0] tail_r [3] = '{4'h0, 4'h0, 4'h0};
  // Drain-source stays high unless the high side conducts into a sound lead
  assign hs_vds_high = ~(high_side_gate & ~lead_short);
  // Charge current tails off eight cycles after the low side opens, longer than
  // the default dead gap, so the high-side hold-off really has to act
  always @(posedge pclk) begin
    for (int p = 0; p < 3; p++) begin
      if (low_side_gate[p] === 1'b1) begin
        tail_r[p] <= 4'h8;
      end else if (tail_r[p] != 4'h0) begin
        tail_r[p] <= tail_r[p] - 4'h1;
      end
    end
  end
  for (genvar p = 0; p < 3; p++) begin : g_boot
    assign boot_charge_high[p] = slow_boot & (low_side_gate[p] | (tail_r[p] != 4'h0));
  end
endmodule

//--- testbench.sv
// Self-checking bench for the brushless gate drive controller
`timescale 1ns/1ps
module testbench;
  import bgdc_pkg::*;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic err; logic pins;} bgdc_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, fault_out, speed_pulse_out;
  logic [2:0] hall_inputs = 3'h5;
  logic pwm_in = 1'b0, current_trip = 1'b0, gate_supply_ok = 1'b1;
  logic temp_over_165 = 1'b0, temp_under_155 = 1'b1;
  logic [2:0] hs_vds_high, boot_charge_high, high_side_gate, low_side_gate;
  logic [2:0] lead_short = 3'h0;
  logic slow_boot = 1'b0;
  bgdc_note_t notes[$];
  bgdc_note_t nt;
  int n_mismatch = 0, n_checks = 0, n_pulse = 0, n_chg = 0;
  integer seed = 11;
  logic [2:0] codes [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

  bgdc_top bgdc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hall_inputs(hall_inputs), .pwm_in(pwm_in),
    .current_trip(current_trip), .gate_supply_ok(gate_supply_ok),
    .temp_over_165(temp_over_165), .temp_under_155(temp_under_155),
    .hs_vds_high(hs_vds_high), .boot_charge_high(boot_charge_high),
    .high_side_gate(high_side_gate), .low_side_gate(low_side_gate),
    .fault_out(fault_out), .speed_pulse_out(speed_pulse_out));
  bgdc_bridge_model bgdc_bridge_model_i (.pclk(pclk), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .lead_short(lead_short), .slow_boot(slow_boot),
    .hs_vds_high(hs_vds_high), .boot_charge_high(boot_charge_high));

  // Free-running 40 MHz clock
  always #12.5 pclk = ~pclk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    cmp_val(name, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask
  // One APB transfer; the expected answer is queued before the request goes out
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic [31:0] m, input logic er);
    int t;
    notes.push_back('{ex, m, er, !wr && a == ADDR_STATUS});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (t >= 50) cmp_bit("pready", 1'b1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic set_hall(input logic [2:0] h);
    @(posedge pclk);
    if (h !== hall_inputs) n_chg++;
    hall_inputs <= h;
  endtask
  // Status read after a settle time: gates, fault flags, optional limit phase
  task automatic chk(input int w, input logic [2:0] hs, input logic [2:0] ls,
                     input logic [4:0] fl, input logic [1:0] cl, input logic mcl);
    idle(w);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000, {16'h0000, cl, ls, hs, 3'h0, fl},
        {16'h0000, {2{mcl}}, 6'h3F, 3'h0, 5'h1F}, 1'b0);
  endtask
  // Commutation selection as {high, low}; reversal swaps the two halves
  function automatic logic [5:0] sel(input logic [2:0] h, input logic dir);
    logic [5:0] v;
    case (h)
      3'h5: v = {3'h1, 3'h4};
      3'h4: v = {3'h2, 3'h4};
      3'h6: v = {3'h2, 3'h1};
      3'h2: v = {3'h4, 3'h1};
      3'h3: v = {3'h4, 3'h2};
      default: v = {3'h1, 3'h2};
    endcase
    return dir ? v : {v[2:0], v[5:3]};
  endfunction

  // Answers are matched against the oldest queued note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      cmp_val("prdata", nt.data & nt.mask, prdata & nt.mask);
      cmp_bit("pslverr", nt.err, pslverr);
      // Status reads also check the gate and fault pins themselves
      if (nt.pins) begin
        cmp_val("gate pins", {26'h000_0000, nt.data[13:8]},
          {26'h000_0000, low_side_gate, high_side_gate});
        cmp_bit("fault_out", nt.data[4], fault_out);
      end
    end
    if (speed_pulse_out === 1'b1) n_pulse++;
  end

  // Hang guard, far beyond the thousand or so cycles the run needs
  initial begin
    #500_000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    logic [5:0] s;
    logic [2:0] h;
    logic [2:0] ehs;
    logic [2:0] els;
    idle(12);
    presetn <= 1'b1;
    slow_boot <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0000_0000, 32'h0000_000F, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, ADDR_DEAD, 32'h0000_0000, 32'h0000_0004, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, ADDR_OFFT, 32'h0000_0000, 32'h0000_0190, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, ADDR_BLANK, 32'h0000_0000, 32'h0000_0028, 32'hFFFF_FFFF, 1'b0);
    apb(1'b0, 12'h014, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 1'b1);
    $display("test registers done");
    // Every decay, rectification, direction and PWM setting on a random Hall state
    for (int i = 0; i < 16; i++) begin
      h = codes[$unsigned($random(seed)) % 6];
      s = sel(h, i[1]);
      wr(ADDR_CTRL, {29'h0000_0001, i[1], i[2], i[3]});
      pwm_in <= i[0];
      set_hall(h);
      ehs = i[0] ? s[5:3] : ((!i[3] && i[2]) ? s[2:0] : 3'h0);
      els = i[0] ? s[2:0] : (i[3] ? (i[2] ? (s[5:3] | s[2:0]) : s[2:0]) : (i[2] ? s[5:3] : 3'h0));
      chk(20, ehs, els, 5'h00, 2'h0, 1'b0);
    end
    $display("test drive table done");
    wr(ADDR_CTRL, 32'h0000_0007);
    pwm_in <= 1'b1;
    set_hall(3'h5);
    chk(20, 3'h0, 3'h7, 5'h00, 2'h0, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0017);
    chk(20, 3'h0, 3'h0, 5'h00, 2'h0, 1'b0);
    wr(ADDR_CTRL, 32'h0000_000F);
    set_hall(3'h0);
    chk(20, 3'h0, 3'h0, 5'h11, 2'h0, 1'b0);
    set_hall(3'h7);
    chk(20, 3'h0, 3'h0, 5'h11, 2'h0, 1'b0);
    set_hall(3'h5);
    gate_supply_ok <= 1'b0;
    chk(20, 3'h0, 3'h0, 5'h12, 2'h0, 1'b0);
    gate_supply_ok <= 1'b1;
    temp_over_165 <= 1'b1;
    temp_under_155 <= 1'b0;
    chk(20, 3'h0, 3'h0, 5'h14, 2'h0, 1'b0);
    temp_over_165 <= 1'b0;
    chk(20, 3'h0, 3'h0, 5'h14, 2'h0, 1'b0);
    temp_under_155 <= 1'b1;
    chk(20, 3'h1, 3'h4, 5'h00, 2'h0, 1'b0);
    $display("test brake and faults done");
    lead_short <= 3'h1;
    chk(40, 3'h0, 3'h4, 5'h18, 2'h0, 1'b0);
    chk(60, 3'h0, 3'h4, 5'h18, 2'h0, 1'b0);
    set_hall(3'h4);
    chk(20, 3'h2, 3'h4, 5'h00, 2'h0, 1'b0);
    lead_short <= 3'h2;
    chk(40, 3'h0, 3'h4, 5'h18, 2'h0, 1'b0);
    lead_short <= 3'h0;
    wr(ADDR_CTRL, 32'h0000_001F);
    wr(ADDR_CTRL, 32'h0000_000F);
    chk(20, 3'h2, 3'h4, 5'h00, 2'h0, 1'b0);
    $display("test short to ground done");
    // Short off and blank counts keep the chopping cycle brief
    wr(ADDR_CTRL, 32'h0000_000D);
    wr(ADDR_OFFT, 32'h0000_003C);
    wr(ADDR_BLANK, 32'h0000_001E);
    set_hall(3'h5);
    idle(20);
    current_trip <= 1'b1;
    idle(2);
    current_trip <= 1'b0;
    chk(0, 3'h0, 3'h4, 5'h00, 2'h1, 1'b1);
    idle(60);
    current_trip <= 1'b1;
    chk(1, 3'h1, 3'h4, 5'h00, 2'h2, 1'b1);
    current_trip <= 1'b0;
    chk(40, 3'h1, 3'h4, 5'h00, 2'h0, 1'b1);
    $display("test current limit done");
    idle(5);
    cmp_val("speed pulses", n_chg, n_pulse);
    $display("test speed pulses done");
    end_sim();
  end
endmodule
